// ### hdl/smoke_seq_pkg.sv
// constants, types and register map of the smoke alarm sequencer
package smoke_seq_pkg;

  // ********************************
  // clock and timing
  // ********************************
  localparam int CLK_MHZ = 200;
  localparam int T_CYCLE_IDLE_US = 1650000;
  localparam int T_CYCLE_SMOKE_US = 41670;
  localparam int T_HORN_HALF_US = 500000;
  localparam int T_STROBE_US = 10000;
  localparam int T_LED_ON_US = 11600;
  localparam int T_LED_SMOKE_US = 1000000;
  localparam logic [31:0] CYCLE_IDLE_CYC = 32'(T_CYCLE_IDLE_US * CLK_MHZ);
  localparam logic [31:0] CYCLE_SMOKE_CYC = 32'(T_CYCLE_SMOKE_US * CLK_MHZ);
  localparam logic [31:0] HORN_HALF_CYC = 32'(T_HORN_HALF_US * CLK_MHZ);
  localparam logic [31:0] STROBE_CYC = 32'(T_STROBE_US * CLK_MHZ);
  localparam logic [31:0] LED_ON_CYC = 32'(T_LED_ON_US * CLK_MHZ);
  localparam logic [31:0] LED_SMOKE_CYC = 32'(T_LED_SMOKE_US * CLK_MHZ);

  // ********************************
  // oscillator cycle slots
  // ********************************
  localparam logic [4:0] BATT_CHECK_CYCLES = 5'h18;
  localparam logic [4:0] BATT_SLOT = 5'h00;
  localparam logic [4:0] CHIRP_SLOT = 5'h0C;

  // ********************************
  // register map
  // ********************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int STS_ALARM_BIT = 0;
  localparam int STS_LOWBAT_BIT = 1;
  localparam int STS_HORN_BIT = 2;
  localparam int STS_LED_BIT = 3;
  localparam int STS_TEST_BIT = 4;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // ********************************
  // types
  // ********************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_STROBE = 4'b0010,
    ST_BATT = 4'b0100,
    ST_CHIRP = 4'b1000
  } seq_state_e;

  typedef struct packed {
    logic horn_en;
    logic led_on;
    logic strobe;
    logic sensitivity_shift;
    logic smoke_out;
    logic lowbat_out;
  } alarm_out_s;

  typedef struct packed {
    logic alarm_end;
    logic lowbat;
    logic smoke;
  } irq_evt_s;

endpackage

// ### hdl/smoke_alarm_sequencer.sv
// smoke alarm sequencer: cycle timing, strobing, horn, led and apb registers
//
// Summary of operation
// - idle cycle 1.65 s, smoke strobe per cycle unless led, chirp or horn busy
// - battery comparison made once every 24 oscillator cycles; the code skips it while in alarm
// - on smoke the cycle becomes 41.67 ms and horn is enabled
// - horn alternates 500 ms sounding and 500 ms silent while in alarm
// - smoke resampled in silent half; absence stops further sounding
// - low battery output held inhibited while in alarm
// - led pulses once per second while in alarm
// - test input low keeps comparators powered, no strobing
// - test mode outputs show raw smoke and low battery continuously
// - each smoke strobe pulse lasts 10 ms; the battery check strobe lasts 11.6 ms
// - battery check made during the led pulse, every 24 cycles; the code skips it while in alarm
// - led held on 11.6 ms during each battery check
// - sensitivity shift asserted while smoke is detected
// - alarm ends only during a silent horn half
// - comparators strobed at most once per oscillator cycle
//
// Our own choices: the register addresses and the APB register port.
module smoke_alarm_sequencer
  import smoke_seq_pkg::*;
#(
  parameter logic [31:0] P_CYCLE_IDLE = CYCLE_IDLE_CYC,
  parameter logic [31:0] P_CYCLE_SMOKE = CYCLE_SMOKE_CYC,
  parameter logic [31:0] P_HORN_HALF = HORN_HALF_CYC,
  parameter logic [31:0] P_STROBE = STROBE_CYC,
  parameter logic [31:0] P_LED_ON = LED_ON_CYC,
  parameter logic [31:0] P_LED_SMOKE = LED_SMOKE_CYC
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  input wire logic smoke_cmp,
  input wire logic lowbat_cmp,
  input wire logic test_n,
  output alarm_out_s alarm_out,
  // interrupt
  output logic irq
);

  // ********************************
  // declarations
  // ********************************
  seq_state_e state_reg;
  logic [31:0] osc_cnt_reg;
  logic [31:0] ph_cnt_reg;
  logic [31:0] horn_cnt_reg;
  logic [31:0] led_cnt_reg;
  logic [31:0] period;
  logic [31:0] ph_len;
  logic [4:0] cyc_idx_reg;
  logic tick;
  logic ph_done;
  logic smoke_sample;
  logic alarm_reg;
  logic horn_on_reg;
  logic lowbat_reg;
  logic run;
  logic [31:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_sts_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic ack_reg;
  logic setup_access;
  logic commit;
  logic mapped;
  logic [31:0] rd_next;
  irq_evt_s evt;
  alarm_out_s alarm_out_next;

  assign run = ctrl_reg[CTRL_RUN_BIT];

  // ********************************
  // oscillator
  // ********************************
  // period follows the alarm state
  assign period = alarm_reg ? P_CYCLE_SMOKE : P_CYCLE_IDLE;
  // >= keeps the wrap safe when the period shrinks mid count
  assign tick = run && (osc_cnt_reg >= period - 32'h1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_cnt_reg <= 32'h0;
    else if (!run || tick)
      osc_cnt_reg <= 32'h0;
    else
      osc_cnt_reg <= osc_cnt_reg + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc_idx_reg <= 5'h0;
    else if (!run)
      cyc_idx_reg <= 5'h0;
    else if (tick)
      cyc_idx_reg <= (cyc_idx_reg == BATT_CHECK_CYCLES - 5'h1) ? 5'h0 : cyc_idx_reg + 5'h1;
  end

  // ********************************
  // sequencer
  // ********************************
  always_comb
  begin
    case (state_reg)
      ST_STROBE: ph_len = P_STROBE;
      ST_BATT: ph_len = P_LED_ON;
      ST_CHIRP: ph_len = P_LED_ON;
      default: ph_len = 32'h1;
    endcase
  end

  assign ph_done = (state_reg != ST_IDLE) && (ph_cnt_reg >= ph_len - 32'h1);
  assign smoke_sample = (state_reg == ST_STROBE) && ph_done;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      ph_cnt_reg <= 32'h0;
    end
    else if (!run)
    begin
      state_reg <= ST_IDLE;
      ph_cnt_reg <= 32'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          ph_cnt_reg <= 32'h0;
          if (tick && !alarm_reg && cyc_idx_reg == BATT_SLOT)
            state_reg <= ST_BATT;
          else if (tick && !alarm_reg && lowbat_reg && cyc_idx_reg == CHIRP_SLOT)
            state_reg <= ST_CHIRP;
          // one strobe per cycle, skipped while horn sounds
          else if (tick && !(alarm_reg && horn_on_reg))
            state_reg <= ST_STROBE;
        end
        ST_STROBE, ST_BATT, ST_CHIRP:
        begin
          if (ph_done)
          begin
            state_reg <= ST_IDLE;
            ph_cnt_reg <= 32'h0;
          end
          else
            ph_cnt_reg <= ph_cnt_reg + 32'h1;
        end
        default:
        begin
          state_reg <= ST_IDLE;
          ph_cnt_reg <= 32'h0;
        end
      endcase
    end
  end

  // ********************************
  // alarm and horn modulation
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_reg <= 1'b0;
      horn_on_reg <= 1'b0;
      horn_cnt_reg <= 32'h0;
    end
    else if (!alarm_reg)
    begin
      horn_cnt_reg <= 32'h0;
      horn_on_reg <= 1'b0;
      // smoke enters alarm with horn sounding
      if (smoke_sample && smoke_cmp)
      begin
        alarm_reg <= 1'b1;
        horn_on_reg <= 1'b1;
      end
    end
    else
    begin
      if (horn_cnt_reg >= P_HORN_HALF - 32'h1)
      begin
        horn_cnt_reg <= 32'h0;
        horn_on_reg <= !horn_on_reg;
      end
      else
        horn_cnt_reg <= horn_cnt_reg + 32'h1;
      if (!horn_on_reg && smoke_sample && !smoke_cmp)
        alarm_reg <= 1'b0;
    end
  end

  // one second led cadence in alarm
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_cnt_reg <= 32'h0;
    else if (!alarm_reg || led_cnt_reg >= P_LED_SMOKE - 32'h1)
      led_cnt_reg <= 32'h0;
    else
      led_cnt_reg <= led_cnt_reg + 32'h1;
  end

  // low battery latch, refreshed each check
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lowbat_reg <= 1'b0;
    else if (state_reg == ST_BATT && ph_done)
      lowbat_reg <= lowbat_cmp;
  end

  // ********************************
  // outputs
  // ********************************
  always_comb
  begin
    alarm_out_next.horn_en = alarm_reg ? horn_on_reg : (state_reg == ST_CHIRP);
    // led loads the battery during the check
    alarm_out_next.led_on = alarm_reg ? (led_cnt_reg < P_LED_ON) : (state_reg == ST_BATT);
    // test mode powers the comparators steadily
    alarm_out_next.strobe = !test_n || state_reg == ST_STROBE || state_reg == ST_BATT;
    alarm_out_next.sensitivity_shift = alarm_reg;
    // raw comparator levels in test mode
    alarm_out_next.smoke_out = !test_n ? smoke_cmp : alarm_reg;
    alarm_out_next.lowbat_out = !test_n ? lowbat_cmp : (lowbat_reg && !alarm_reg);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alarm_out <= '0;
    else
      alarm_out <= alarm_out_next;
  end

  // ********************************
  // apb slave
  // ********************************
  // one wait state so read data comes from a flop
  assign setup_access = psel && penable && !ack_reg;
  assign commit = psel && penable && ack_reg;
  assign pready = ack_reg;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                  (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK);
  assign pslverr = ack_reg && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ack_reg <= 1'b0;
    else
      ack_reg <= setup_access;
  end

  always_comb
  begin
    rd_next = 32'h0;
    case (paddr)
      ADDR_CTRL: rd_next = ctrl_reg;
      ADDR_STATUS:
      begin
        rd_next[STS_ALARM_BIT] = alarm_reg;
        rd_next[STS_LOWBAT_BIT] = lowbat_reg;
        rd_next[STS_HORN_BIT] = alarm_out.horn_en;
        rd_next[STS_LED_BIT] = alarm_out.led_on;
        rd_next[STS_TEST_BIT] = !test_n;
      end
      ADDR_IRQ_STATUS: rd_next[IRQ_W-1:0] = irq_sts_reg;
      ADDR_IRQ_MASK: rd_next[IRQ_W-1:0] = irq_mask_reg;
      default: rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (setup_access && !pwrite)
      prdata <= rd_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end
    else if (commit && pwrite)
    begin
      if (paddr == ADDR_CTRL)
        ctrl_reg <= {31'h0, pwdata[CTRL_RUN_BIT]};
      if (paddr == ADDR_IRQ_MASK)
        irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // ********************************
  // interrupts
  // ********************************
  assign evt.smoke = !alarm_reg && smoke_sample && smoke_cmp;
  assign evt.lowbat = (state_reg == ST_BATT) && ph_done && lowbat_cmp;
  assign evt.alarm_end = alarm_reg && !horn_on_reg && smoke_sample && !smoke_cmp;

  // read clears; a new event in the same cycle survives the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_sts_reg <= '0;
    else if (commit && !pwrite && paddr == ADDR_IRQ_STATUS)
      irq_sts_reg <= evt;
    else
      irq_sts_reg <= irq_sts_reg | evt;
  end

  assign irq = |(irq_sts_reg & irq_mask_reg);

endmodule // smoke_alarm_sequencer

// ### sim/smoke_env_model.sv
// analog side stand-in: comparators that answer only while powered
module smoke_env_model
(
  // clock and power
  input wire logic pclk,
  input wire logic power,
  // environment set by the bench
  input wire logic smoke_env,
  input wire logic lowbat_env,
  // comparator outputs
  output logic smoke_cmp = 1'b0,
  output logic lowbat_cmp = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // valid only when powered
  // unpowered outputs toggle, so a stale sample never passes as valid
  always @(posedge pclk)
  begin
    smoke_cmp <= power ? smoke_env : !smoke_cmp;
    lowbat_cmp <= power ? lowbat_env : !lowbat_cmp;
  end
endmodule // smoke_env_model

// ### sim/smoke_alarm_sequencer_props.sv
// assertion checker bound to the smoke alarm sequencer
module smoke_seq_props
  import smoke_seq_pkg::*;
#(
  parameter int STB = 4,
  parameter int LON = 5,
  parameter int HH = 60,
  parameter int LSM = 30
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // watched ports
  input wire logic smoke_cmp,
  input wire logic lowbat_cmp,
  input wire logic test_n,
  input wire alarm_out_s alarm_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S1 = STB - 1;
  localparam int L1 = LON - 1;
  localparam int H1 = HH - 1;
  localparam int G1 = LSM - LON - 1;
  logic hn, ld, sb, sh;
  assign {hn, ld, sb, sh} = alarm_out[5:2];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // horn halves
  // ****
  sequence horn_on_s;
    hn throughout ##H1 1'b1;
  endsequence
  sequence horn_off_s;
    !hn throughout ##H1 1'b1;
  endsequence
  reset_quiet_a:
    assert property (disable iff (1'b0) !presetn |-> alarm_out == '0 && !irq)
    else $error("output active in reset");
  lowbat_inhibit_a:
    assert property (test_n && $past(test_n) && sh |-> !alarm_out.lowbat_out)
    else $error("low battery shown in alarm");
  test_follow_a:
    assert property (!test_n |=> alarm_out.smoke_out == $past(smoke_cmp)
      && alarm_out.lowbat_out == $past(lowbat_cmp)) else $error("test outputs wrong");
  test_power_a:
    assert property (!test_n |=> sb) else $error("strobe off in test");
  strobe_width_a:
    assert property ($rose(sb) && !ld && test_n |-> (sb throughout ##S1 1'b1)
      ##1 (!sb || !test_n)) else $error("strobe width wrong");
  batt_pulse_a:
    assert property ($rose(ld) && !sh |-> (ld && sb throughout ##L1 1'b1) ##1 !ld)
    else $error("battery pulse wrong");
  horn_half_a:
    assert property ($rose(hn) && sh |-> horn_on_s ##1 !hn) else $error("horn on wrong");
  silent_half_a:
    assert property ($fell(hn) && sh |-> horn_off_s ##1 (hn || !sh))
    else $error("horn off wrong");
  alarm_end_a:
    assert property ($fell(sh) |-> !hn && !$past(hn)) else $error("alarm ended sounding");
  alarm_entry_a:
    assert property ($rose(sh) && test_n |-> hn && ld && alarm_out.smoke_out)
    else $error("alarm entry wrong");
  led_rate_a:
    assert property ($rose(ld) && sh |-> ((ld || !sh) throughout ##L1 1'b1)
      ##1 ((!ld || !sh) throughout ##G1 1'b1) ##1 (ld || !sh)) else $error("led rate wrong");
endmodule // smoke_seq_props

bind smoke_alarm_sequencer smoke_seq_props #(.STB(P_STROBE), .LON(P_LED_ON),
  .HH(P_HORN_HALF), .LSM(P_LED_SMOKE)) props_u (.pclk(pclk), .presetn(presetn),
  .smoke_cmp(smoke_cmp), .lowbat_cmp(lowbat_cmp), .test_n(test_n),
  .alarm_out(alarm_out), .irq(irq));

// ### sim/tb_smoke_alarm_sequencer.sv
// self-checking bench of the smoke alarm sequencer
module tb_smoke_alarm_sequencer
  import smoke_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic test_n = 1'b1;
  logic smoke_env = 1'b0;
  logic lowbat_env = 1'b1;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, smoke_cmp, lowbat_cmp, hit, err;
  alarm_out_s alarm_out;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  // small counts keep the run short; every expectation uses them
  localparam logic [31:0] IDLE_LEN = 32'h28;
  localparam logic [31:0] SMOKE_LEN = 32'h14;
  localparam logic [31:0] HORN_LEN = 32'h3C;
  localparam logic [31:0] STB_LEN = 32'h4;
  localparam logic [31:0] LED_LEN = 32'h5;
  localparam logic [31:0] LED_PER = 32'h1E;
  smoke_alarm_sequencer #(.P_CYCLE_IDLE(IDLE_LEN), .P_CYCLE_SMOKE(SMOKE_LEN),
    .P_HORN_HALF(HORN_LEN), .P_STROBE(STB_LEN), .P_LED_ON(LED_LEN), .P_LED_SMOKE(LED_PER))
  dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smoke_cmp(smoke_cmp), .lowbat_cmp(lowbat_cmp), .test_n(test_n),
    .alarm_out(alarm_out), .irq(irq));
  smoke_env_model env_u (.pclk(pclk), .power(alarm_out.strobe), .smoke_env(smoke_env),
    .lowbat_env(lowbat_env), .smoke_cmp(smoke_cmp), .lowbat_cmp(lowbat_cmp));
  initial forever #2.5 pclk = !pclk;
  always @(posedge pclk) cyc++;
  task conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task wt(input int b, input logic v, input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++)
    begin
      @(posedge pclk);
      #1;
      hit = (alarm_out[b] === v);
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude();
  end
  initial
  begin
    // a real falling edge at time zero so the async reset acts before the first sample
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q, CTRL_RESET)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, ADDR_IRQ_MASK, 32'h7);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    `CHK(q, 32'h7)
    // run cleared: no strobe may appear while the sequencer is held
    apb(1'b1, ADDR_CTRL, 32'h0);
    wt(3, 1'b1, 60);
    `CHK(hit, 1'b0)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b1, ADDR_CTRL, 32'h1);
    $display("register test done");
    wt(4, 1'b1, 100);
    t0 = cyc;
    `CHK(alarm_out.strobe, 1'b1)
    wt(4, 1'b0, 10);
    wt(0, 1'b1, 3);
    `CHK(hit, 1'b1)
    `CHK(irq, 1'b1)
    wt(3, 1'b1, 60);
    `CHK(cyc - t0, IDLE_LEN)
    wt(5, 1'b1, 600);
    `CHK(cyc - t0, 480)
    wt(4, 1'b1, 600);
    `CHK(cyc - t0, 960)
    repeat (8) @(posedge pclk);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    `CHK(q, 32'h2)
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    `CHK(q, 32'h0)
    `CHK(irq, 1'b0)
    $display("standby test done");
    @(posedge pclk);
    smoke_env <= 1'b1;
    wt(2, 1'b1, 100);
    `CHK(alarm_out.lowbat_out, 1'b0)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q & 32'h7, 32'h7)
    wt(5, 1'b0, 100);
    wt(3, 1'b1, 40);
    t0 = cyc;
    wt(3, 1'b0, 10);
    wt(3, 1'b1, 40);
    `CHK(cyc - t0, SMOKE_LEN)
    @(posedge pclk);
    smoke_env <= 1'b0;
    wt(2, 1'b0, 300);
    `CHK(alarm_out.horn_en, 1'b0)
    wt(5, 1'b1, 60);
    `CHK(hit, 1'b0)
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    `CHK(irq, 1'b0)
    apb(1'b1, ADDR_IRQ_MASK, 32'h5);
    `CHK(irq, 1'b1)
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    `CHK(q & 32'h5, 32'h5)
    `CHK(irq, 1'b0)
    $display("alarm test done");
    @(posedge pclk);
    test_n <= 1'b0;
    lowbat_env <= 1'b0;
    smoke_env <= 1'b1;
    repeat (5) @(posedge pclk);
    #1;
    `CHK(alarm_out.strobe, 1'b1)
    `CHK(alarm_out.smoke_out, 1'b1)
    `CHK(alarm_out.lowbat_out, 1'b0)
    @(posedge pclk);
    lowbat_env <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    `CHK(alarm_out.lowbat_out, 1'b1)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[STS_TEST_BIT], 1'b1)
    $display("test mode done");
    conclude();
  end
endmodule // tb_smoke_alarm_sequencer
